// ---- logic/sfpb_consts.vh ----
`ifndef SFPB_CONSTS_VH
`define SFPB_CONSTS_VH
// command opcodes
`define SFPB_OP_PP      8'h02
`define SFPB_OP_QPP     8'h32
`define SFPB_OP_BCLR    8'h9e
`define SFPB_OP_BLOAD   8'h9a
`define SFPB_OP_BREAD   8'h9b
`define SFPB_OP_BWRITE  8'h9c
`define SFPB_OP_BPROG   8'h9d
`define SFPB_OP_OTPERA  8'h44
// frame byte counts (opcode, address done, dummy done)
`define SFPB_BC_OPC     3'h1
`define SFPB_BC_ADDR    3'h4
`define SFPB_BC_DATA    3'h5
// bit counter steps
`define SFPB_LAST_BIT1  3'h7
`define SFPB_LAST_BIT4  3'h4
// buffer geometry
`define SFPB_ERASED     8'hff
`define SFPB_MASK_NORM  10'h0ff
`define SFPB_MASK_DUAL  10'h1ff
`define SFPB_PAGE_LAST  10'h0ff
// lockable register address fields
`define SFPB_SEL_MIN    4'h1
`define SFPB_SEL_MAX    4'h3
// timing, in nanoseconds
`define SFPB_CLK_NS     10
`define SFPB_T_PP_NS    400000
`define SFPB_T_BC_NS    20000
`define SFPB_T_XFR_NS   30000
`define SFPB_T_SE_NS    800000
`endif

// ---- logic/sfpb_core.v ----
`timescale 1ns/1ps
`include "sfpb_consts.vh"
// How it works
// - page program needs write enable latch set
// - over 256 bytes: last 256 kept
// - data past page end wraps within page
// - short program touches only sent bytes
// - select rising mid-byte cancels the program
// - select rise starts timed cycle, busy, latch clears
// - protected page skipped; upper lines ignored
// - quad program needs latch and quad enable
// - quad program: address single line, data four
// - buffer clear fills 0xff, busy for latency
// - buffer size follows dual page mode
// - buffer load copies page, busy while copying
// - buffer read: address, dummy, wrapping output
// - buffer read refused while cycle running
// - buffer write stores with wrapping increment
// - buffer program: latch, timed, protection checked
// - lockable register erase: latch, address, timed
// - erase only when select rises on boundary
// - locked register ignores erase
// - register chosen by address bits 15..12

// small fifo between program engine and array port
module sfpb_fifo #(
  parameter W  = 32,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire         clk,       // clock
  input  wire         rst_n,     // sync reset
  input  wire         in_valid,  // write request
  output wire         in_ready,  // room left
  input  wire [W-1:0] in_data,   // write word
  output wire         out_valid, // word available
  input  wire         out_ready, // consumer takes
  output wire [W-1:0] out_data,  // head word
  output wire         empty      // nothing stored
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0]   cnt;
  wire do_w = in_valid & in_ready;
  wire do_r = out_valid & out_ready;
  assign in_ready  = (cnt != D);
  assign out_valid = (cnt != 0);
  assign empty     = (cnt == 0);
  assign out_data  = mem[rptr];
  // pointer and count update
  always @(posedge clk) begin
    if (!rst_n) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      cnt  <= {(AW+1){1'b0}};
    end else begin
      if (do_w) begin
        mem[wptr] <= in_data;
        wptr <= wptr + 1'b1;
      end
      if (do_r)
        rptr <= rptr + 1'b1;
      if (do_w & ~do_r)
        cnt <= cnt + 1'b1;
      else if (do_r & ~do_w)
        cnt <= cnt - 1'b1;
    end
  end
endmodule

module sfpb_core #(
  parameter PP_TIME_NS  = `SFPB_T_PP_NS,
  parameter BC_TIME_NS  = `SFPB_T_BC_NS,
  parameter XFR_TIME_NS = `SFPB_T_XFR_NS,
  parameter SE_TIME_NS  = `SFPB_T_SE_NS
) (
  input  wire        CLOCK,              // system clock
  input  wire        NRST,               // sync reset, low
  input  wire        CS_N,               // chip select pin
  input  wire        SCLK,               // serial clock pin
  input  wire [3:0]  SIO_IN,             // io line inputs
  output wire [3:0]  SIO_OUT,            // io line outputs
  output wire [3:0]  SIO_OE_N,           // io enables, low drives
  input  wire        WEL_SET,            // latch set pulse
  input  wire        QUAD_ENABLE_BIT,    // quad enable
  input  wire        DUAL_PAGE_MODE,     // 512 byte buffer
  input  wire [2:0]  OTP_LOCK_BITS,      // register locks
  output wire [15:0] TARGET_PAGE,        // page to check
  input  wire        TARGET_PROTECTED,   // page protected
  output wire        WRITE_IN_PROGRESS,  // busy status
  output wire        WRITE_ENABLE_LATCH, // latch status
  output wire        ARRAY_WR_VALID,     // array byte write
  input  wire        ARRAY_WR_READY,     // array accepts
  output wire [23:0] ARRAY_WR_ADDR,      // write address
  output wire [7:0]  ARRAY_WR_DATA,      // write byte
  output wire        ARRAY_RD_EN,        // array read strobe
  output wire [23:0] ARRAY_RD_ADDR,      // read address
  input  wire [7:0]  ARRAY_RD_DATA,      // data same cycle as strobe
  output wire        OTP_ERASE_START,    // erase pulse
  output wire [1:0]  OTP_ERASE_SEL       // register index
);
  // cycle counts, rounded up, then cut to the timer width on purpose
  localparam integer PP_CYC_I  = (PP_TIME_NS + `SFPB_CLK_NS - 1) / `SFPB_CLK_NS;
  localparam integer BC_CYC_I  = (BC_TIME_NS + `SFPB_CLK_NS - 1) / `SFPB_CLK_NS;
  localparam integer XFR_CYC_I = (XFR_TIME_NS + `SFPB_CLK_NS - 1) / `SFPB_CLK_NS;
  localparam integer SE_CYC_I  = (SE_TIME_NS + `SFPB_CLK_NS - 1) / `SFPB_CLK_NS;
  localparam [23:0] PP_CYC  = PP_CYC_I[23:0];
  localparam [23:0] BC_CYC  = BC_CYC_I[23:0];
  localparam [23:0] XFR_CYC = XFR_CYC_I[23:0];
  localparam [23:0] SE_CYC  = SE_CYC_I[23:0];
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RUN  = 2'h1;
  localparam [1:0] S_WAIT = 2'h2;
  localparam [2:0] K_PP   = 3'h0;
  localparam [2:0] K_BUF  = 3'h1;
  localparam [2:0] K_LOAD = 3'h2;
  localparam [2:0] K_CLR  = 3'h3;
  localparam [2:0] K_ERA  = 3'h4;

  // array address of buffer slot i
  function [23:0] page_addr;
    input [23:0] a;
    input        dual;
    input [9:0]  i;
    begin
      if (dual)
        page_addr = {a[23:9], i[8:0]};
      else
        page_addr = {a[23:8], i[7:0]};
    end
  endfunction

  reg [1:0]  cs_s;
  reg [1:0]  ck_s;
  reg [3:0]  io_a;
  reg [3:0]  io_b;
  reg        ck_d;
  reg        cs_d;
  reg [7:0]  sh;
  reg [2:0]  bitc;
  reg [2:0]  bcnt;
  reg        byte_stb;
  reg [2:0]  byte_idx;
  reg [7:0]  byte_val;
  reg [7:0]  opc;
  reg        accept;
  reg [23:0] addr;
  reg [7:0]  pp_ptr;
  reg [9:0]  bptr;
  reg [7:0]  pp_mem [0:255];
  reg [255:0] pp_mask;
  reg [7:0]  buf_mem [0:511];
  reg        rd_act;
  reg [7:0]  out_sh;
  reg [2:0]  ocnt;
  reg        so;
  reg [1:0]  st;
  reg [2:0]  kind;
  reg        eng_dual;
  reg [9:0]  idx;
  reg [9:0]  last;
  reg [23:0] timer;
  reg        ld_v;
  reg [9:0]  ld_i;
  reg        rd_en;
  reg [23:0] rd_addr;
  reg        write_in_progress;
  reg        write_enable_latch;
  reg        era_stb;
  reg [1:0]  era_sel;

  wire cs_n    = cs_s[1];
  wire rise    = ck_s[1] & ~ck_d & ~cs_n;
  wire fall    = ~ck_s[1] & ck_d & ~cs_n;
  wire cs_rise = cs_n & ~cs_d;
  wire cs_fall = ~cs_n & cs_d;
  wire qmode   = accept & (opc == `SFPB_OP_QPP) & (bcnt >= `SFPB_BC_ADDR);
  wire [9:0] bmask = DUAL_PAGE_MODE ? `SFPB_MASK_DUAL : `SFPB_MASK_NORM;
  wire [3:0] sel = addr[15:12];
  wire [1:0] sel_i = sel[1:0] - 2'h1;
  wire otp_ok = (addr[23:16] == 8'h00) && (addr[11:9] == 3'h0) &&
                (sel >= `SFPB_SEL_MIN) && (sel <= `SFPB_SEL_MAX);
  wire aligned = (bitc == 3'h0);
  wire prog = (st == S_RUN) & ((kind == K_PP) | (kind == K_BUF));
  wire src_v = (kind == K_BUF) | pp_mask[idx[7:0]];
  wire [7:0] src_b = (kind == K_BUF) ? buf_mem[idx[8:0]] : pp_mem[idx[7:0]];
  wire f_in_ready;
  wire f_empty;
  wire [31:0] f_out;
  wire f_push = prog & src_v;
  wire step = (st == S_RUN) & (~prog | ~src_v | f_in_ready);

  sfpb_fifo #(
    .W  (32),
    .D  (16),
    .AW (4)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (NRST),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   ({page_addr(addr, eng_dual, idx), src_b}),
    .out_valid (ARRAY_WR_VALID),
    .out_ready (ARRAY_WR_READY),
    .out_data  (f_out),
    .empty     (f_empty)
  );

  assign ARRAY_WR_ADDR      = f_out[31:8];
  assign ARRAY_WR_DATA      = f_out[7:0];
  assign ARRAY_RD_EN        = rd_en;
  assign ARRAY_RD_ADDR      = rd_addr;
  assign TARGET_PAGE        = addr[23:8];
  assign WRITE_IN_PROGRESS  = write_in_progress;
  assign WRITE_ENABLE_LATCH = write_enable_latch;
  assign OTP_ERASE_START    = era_stb;
  assign OTP_ERASE_SEL      = era_sel;
  assign SIO_OUT            = {2'h0, so, 1'b0};
  assign SIO_OE_N           = {2'h3, ~rd_act, 1'b1};

  // pin sync and bit assembly
  always @(posedge CLOCK) begin
    if (!NRST) begin
      cs_s     <= 2'h3;
      ck_s     <= 2'h0;
      io_a     <= 4'h0;
      io_b     <= 4'h0;
      ck_d     <= 1'b0;
      cs_d     <= 1'b1;
      sh       <= 8'h00;
      bitc     <= 3'h0;
      bcnt     <= 3'h0;
      byte_stb <= 1'b0;
      byte_idx <= 3'h0;
      byte_val <= 8'h00;
    end else begin
      cs_s     <= {cs_s[0], CS_N};
      ck_s     <= {ck_s[0], SCLK};
      io_a     <= SIO_IN;
      io_b     <= io_a;
      ck_d     <= ck_s[1];
      cs_d     <= cs_s[1];
      byte_stb <= 1'b0;
      if (cs_fall) begin
        bitc <= 3'h0;
        bcnt <= 3'h0;
      end else if (rise) begin
        if (qmode) begin
          sh   <= {sh[3:0], io_b};
          bitc <= bitc + `SFPB_LAST_BIT4;
        end else begin
          sh   <= {sh[6:0], io_b[0]};
          bitc <= bitc + 3'h1;
        end
        if (bitc == (qmode ? `SFPB_LAST_BIT4 : `SFPB_LAST_BIT1)) begin
          byte_stb <= 1'b1;
          byte_idx <= bcnt;
          byte_val <= qmode ? {sh[3:0], io_b} : {sh[6:0], io_b[0]};
          if (bcnt != `SFPB_BC_DATA)
            bcnt <= bcnt + 3'h1;
        end
      end
    end
  end

  // command decode, buffer access and timed engine
  always @(posedge CLOCK) begin
    if (!NRST) begin
      opc      <= 8'h00;
      accept   <= 1'b0;
      addr     <= 24'h000000;
      pp_ptr   <= 8'h00;
      bptr     <= 10'h000;
      pp_mask  <= {256{1'b0}};
      rd_act   <= 1'b0;
      out_sh   <= 8'h00;
      ocnt     <= 3'h0;
      so       <= 1'b0;
      st       <= S_IDLE;
      kind     <= K_PP;
      eng_dual <= 1'b0;
      idx      <= 10'h000;
      last     <= 10'h000;
      timer    <= 24'h000000;
      ld_v     <= 1'b0;
      ld_i     <= 10'h000;
      rd_en    <= 1'b0;
      rd_addr  <= 24'h000000;
      write_in_progress      <= 1'b0;
      write_enable_latch      <= 1'b0;
      era_stb  <= 1'b0;
      era_sel  <= 2'h0;
    end else begin
      era_stb <= 1'b0;
      rd_en   <= 1'b0;
      ld_v    <= 1'b0;
      if (timer != 24'h000000)
        timer <= timer - 24'h000001;
      // incoming bytes
      if (byte_stb) begin
        if (byte_idx == 3'h0) begin
          opc    <= byte_val;
          accept <= ~write_in_progress;
          if (byte_val == `SFPB_OP_PP || byte_val == `SFPB_OP_QPP)
            if (~write_in_progress)
              pp_mask <= {256{1'b0}};
        end else if (accept && byte_idx < `SFPB_BC_ADDR) begin
          addr <= {addr[15:0], byte_val};
          if (byte_idx == `SFPB_BC_ADDR - 3'h1) begin
            pp_ptr <= byte_val;
            bptr   <= {addr[1:0], byte_val} & bmask;
          end
        end else if (accept) begin
          case (opc)
            `SFPB_OP_PP, `SFPB_OP_QPP: begin
              pp_mem[pp_ptr]  <= byte_val;
              pp_mask[pp_ptr] <= 1'b1;
              pp_ptr          <= pp_ptr + 8'h01;
            end
            `SFPB_OP_BWRITE: begin
              buf_mem[bptr[8:0]] <= byte_val;
              bptr <= (bptr + 10'h001) & bmask;
            end
            `SFPB_OP_BREAD: begin
              if (byte_idx == `SFPB_BC_ADDR) begin
                rd_act <= 1'b1;
                out_sh <= buf_mem[bptr[8:0]];
                bptr   <= (bptr + 10'h001) & bmask;
                ocnt   <= 3'h0;
              end
            end
            default: begin
            end
          endcase
        end
      end
      // read data shifted out on falling edges
      if (fall && rd_act) begin
        so <= out_sh[7];
        if (ocnt == `SFPB_LAST_BIT1) begin
          out_sh <= buf_mem[bptr[8:0]];
          bptr   <= (bptr + 10'h001) & bmask;
          ocnt   <= 3'h0;
        end else begin
          out_sh <= {out_sh[6:0], 1'b0};
          ocnt   <= ocnt + 3'h1;
        end
      end
      // end of frame starts a command
      if (cs_rise) begin
        rd_act <= 1'b0;
        accept <= 1'b0;
        if (accept && ~write_in_progress && aligned) begin
          eng_dual <= DUAL_PAGE_MODE;
          idx      <= 10'h000;
          last     <= bmask;
          case (opc)
            `SFPB_OP_PP, `SFPB_OP_QPP: begin
              if (bcnt == `SFPB_BC_DATA && write_enable_latch && ~TARGET_PROTECTED &&
                  (opc == `SFPB_OP_PP || QUAD_ENABLE_BIT)) begin
                st       <= S_RUN;
                kind     <= K_PP;
                write_in_progress      <= 1'b1;
                eng_dual <= 1'b0;
                last     <= `SFPB_PAGE_LAST;
                timer    <= PP_CYC;
              end
            end
            `SFPB_OP_BCLR: begin
              st    <= S_RUN;
              kind  <= K_CLR;
              write_in_progress   <= 1'b1;
              timer <= BC_CYC;
            end
            `SFPB_OP_BLOAD: begin
              if (bcnt >= `SFPB_BC_ADDR) begin
                st    <= S_RUN;
                kind  <= K_LOAD;
                write_in_progress   <= 1'b1;
                timer <= XFR_CYC;
              end
            end
            `SFPB_OP_BPROG: begin
              if (bcnt >= `SFPB_BC_ADDR && write_enable_latch && ~TARGET_PROTECTED) begin
                st    <= S_RUN;
                kind  <= K_BUF;
                write_in_progress   <= 1'b1;
                timer <= PP_CYC;
              end
            end
            `SFPB_OP_OTPERA: begin
              if (bcnt == `SFPB_BC_ADDR && write_enable_latch && otp_ok &&
                  ~OTP_LOCK_BITS[sel_i]) begin
                st      <= S_WAIT;
                kind    <= K_ERA;
                write_in_progress     <= 1'b1;
                era_stb <= 1'b1;
                era_sel <= sel_i;
                timer   <= SE_CYC;
              end
            end
            default: begin
            end
          endcase
        end
      end
      // engine walk over buffer slots
      case (st)
        S_RUN: begin
          if (kind == K_CLR)
            buf_mem[idx[8:0]] <= `SFPB_ERASED;
          if (kind == K_LOAD) begin
            rd_en   <= 1'b1;
            rd_addr <= page_addr(addr, eng_dual, idx);
            ld_v    <= 1'b1;
            ld_i    <= idx;
          end
          if (step) begin
            idx <= idx + 10'h001;
            if (idx == last)
              st <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (timer == 24'h000000 && f_empty && ~ld_v) begin
            st  <= S_IDLE;
            write_in_progress <= 1'b0;
            if (kind != K_CLR && kind != K_LOAD)
              write_enable_latch <= 1'b0;
          end
        end
        default: begin
        end
      endcase
      if (ld_v)
        buf_mem[ld_i[8:0]] <= ARRAY_RD_DATA;
      if (WEL_SET)
        write_enable_latch <= 1'b1;
    end
  end
endmodule

// ---- verif/sfpb_host.sv ----
`timescale 1ns/1ps
// host side of the serial link, mode 0, 160 ns bit clock
module sfpb_host (
  output logic       cs_n, // chip select, low active
  output logic       sclk, // serial clock, idle low
  output logic [3:0] sio,  // io lines toward core
  input  wire logic  so    // read data from core
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sio  = 4'h5;
  end
  // select low, clock stands still until bits flow
  task automatic open_frame;
    cs_n = 1'b0;
    #80;
  endtask
  // msb first on line zero, or high nibble first on all four lines
  task automatic xfer(input logic [7:0] b, input logic quad, input int nclk,
                      output logic [7:0] r);
    logic [7:0] sh;
    int i;
    sh = b;
    r = 8'h00;
    for (i = 0; i < nclk; i++) begin
      sio = quad ? sh[7:4] : {~sio[3:1], sh[7]};
      sh = quad ? (sh << 4) : (sh << 1);
      #80 sclk = 1'b1;
      r = {r[6:0], so};
      #80 sclk = 1'b0;
    end
  endtask
  // deselect; released lines show the inverse of their last value
  task automatic close_frame;
    #80 cs_n = 1'b1;
    sio = ~sio;
  endtask
endmodule

// ---- verif/sfpb_properties.sv ----
`timescale 1ns/1ps
// pin level ordering of busy, latch, array strobes and read enables
module sfpb_properties (
  input wire logic        CLOCK,              // system clock
  input wire logic        NRST,               // sync reset, low
  input wire logic        CS_N,               // chip select
  input wire logic [3:0]  SIO_OE_N,           // io enables, low drives
  input wire logic [2:0]  OTP_LOCK_BITS,      // register locks
  input wire logic [15:0] TARGET_PAGE,        // captured page
  input wire logic        WRITE_IN_PROGRESS,  // busy
  input wire logic        WRITE_ENABLE_LATCH, // latch
  input wire logic        ARRAY_WR_VALID,     // array write
  input wire logic [23:0] ARRAY_WR_ADDR,      // write address
  input wire logic        ARRAY_RD_EN,        // array read
  input wire logic        OTP_ERASE_START,    // erase pulse
  input wire logic [1:0]  OTP_ERASE_SEL       // register index
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // busy starts only once select is back high
  a_busy_after_cs: assert property ($rose(WRITE_IN_PROGRESS) |-> CS_N)
    else $error("busy rose while selected");
  a_busy_holds: assert property ($rose(WRITE_IN_PROGRESS) |=> WRITE_IN_PROGRESS [*8])
    else $error("busy too short");
  a_latch_clear: assert property ($fell(WRITE_ENABLE_LATCH) |-> $fell(WRITE_IN_PROGRESS))
    else $error("latch cleared outside cycle end");
  // array writes belong to a running, enabled cycle in the 512 byte block of the captured page; array reads to a running cycle
  a_write_in_cycle: assert property (ARRAY_WR_VALID |-> WRITE_IN_PROGRESS)
    else $error("array write outside cycle");
  a_write_latch: assert property (ARRAY_WR_VALID |-> WRITE_ENABLE_LATCH)
    else $error("array write without latch");
  a_write_in_page: assert property (ARRAY_WR_VALID |-> ARRAY_WR_ADDR[23:9] == TARGET_PAGE[15:1])
    else $error("array write left its page");
  a_load_in_cycle: assert property (ARRAY_RD_EN |-> WRITE_IN_PROGRESS)
    else $error("array read outside cycle");
  // read output only on line one, never while busy, dropped after deselect
  a_read_idle: assert property (!SIO_OE_N[1] |-> !WRITE_IN_PROGRESS)
    else $error("read data while busy");
  a_oe_lines: assert property (SIO_OE_N[0] && SIO_OE_N[3:2] == 2'b11)
    else $error("unused line driven");
  a_oe_release: assert property ($rose(CS_N) |-> ##[1:6] SIO_OE_N[1])
    else $error("read driver not released");
  // erase strobe: valid index, unlocked, enabled, single cycle
  a_erase_guard: assert property (OTP_ERASE_START |-> OTP_ERASE_SEL != 2'h3 &&
      !OTP_LOCK_BITS[OTP_ERASE_SEL] && WRITE_ENABLE_LATCH)
    else $error("erase start not allowed");
  a_erase_pulse: assert property (OTP_ERASE_START |=> !OTP_ERASE_START)
    else $error("erase start too long");
  c_busy: cover property ($rose(WRITE_IN_PROGRESS));
  c_erase: cover property (OTP_ERASE_START);
  c_read: cover property (!SIO_OE_N[1]);
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "sfpb_consts.vh"
module testbench;
  logic        clk, nrst, wel_set, qe, dual, prot, cs_n, sclk, wr_valid, wr_ready;
  logic        rd_en, erase, write_in_progress, write_enable_latch;
  logic [2:0]  locks;
  logic [3:0]  sio, so, oe_n;
  logic [15:0] page;
  logic [23:0] wr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data;
  logic [1:0]  sel, last_sel, rdy_cnt;
  logic [7:0]  wr_mem [int];
  logic [7:0]  dat [0:3];
  logic [7:0]  got [0:3];
  int          n_errors, n_tests, n_wr, n_erase, n_oe;

  sfpb_host host (.cs_n(cs_n), .sclk(sclk), .sio(sio), .so(so[1]));
  sfpb_core #(.PP_TIME_NS(200), .BC_TIME_NS(200), .XFR_TIME_NS(200), .SE_TIME_NS(200)) DUT (
    .CLOCK(clk), .NRST(nrst), .CS_N(cs_n), .SCLK(sclk), .SIO_IN(sio), .SIO_OUT(so),
    .SIO_OE_N(oe_n), .WEL_SET(wel_set), .QUAD_ENABLE_BIT(qe), .DUAL_PAGE_MODE(dual),
    .OTP_LOCK_BITS(locks), .TARGET_PAGE(page), .TARGET_PROTECTED(prot),
    .WRITE_IN_PROGRESS(write_in_progress), .WRITE_ENABLE_LATCH(write_enable_latch), .ARRAY_WR_VALID(wr_valid),
    .ARRAY_WR_READY(wr_ready), .ARRAY_WR_ADDR(wr_addr), .ARRAY_WR_DATA(wr_data),
    .ARRAY_RD_EN(rd_en), .ARRAY_RD_ADDR(rd_addr), .ARRAY_RD_DATA(rd_data),
    .OTP_ERASE_START(erase), .OTP_ERASE_SEL(sel));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // array side: accepts one cycle in four so the fifo backs up
  assign wr_ready = (rdy_cnt == 2'h0);
  // read data stands in the same cycle as the strobe, as the core samples it
  assign rd_data = ~rd_addr[7:0];
  always @(posedge clk) begin
    rdy_cnt <= rdy_cnt + 2'h1;
    if (wr_valid && wr_ready) begin
      wr_mem[int'(wr_addr)] = wr_data;
      n_wr++;
    end
    if (erase) begin
      n_erase++;
      last_sel <= sel;
    end
    if (!oe_n[1]) n_oe++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_wel;
    tick(1);
    wel_set = 1'b1;
    tick(1);
    wel_set = 1'b0;
  endtask
  // opcode, address, dummy, data or read bytes, optional partial tail
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nd,
                       input logic quad, input int tail);
    logic [7:0] r;
    int i;
    tick(1);
    host.open_frame();
    host.xfer(op, 1'b0, 8, r);
    if (op != `SFPB_OP_BCLR) for (i = 2; i >= 0; i--) host.xfer(a[8*i +: 8], 1'b0, 8, r);
    if (op == `SFPB_OP_BREAD) host.xfer(8'h00, 1'b0, 8, r);
    for (i = 0; i < nd; i++) begin
      host.xfer(dat[i], quad, quad ? 2 : 8, r);
      got[i] = r;
    end
    if (tail > 0) host.xfer(8'h00, 1'b0, tail, r);
    host.close_frame();
    tick(8);
  endtask
  task automatic idle;
    int k;
    for (k = 0; k < 5000 && write_in_progress !== 1'b0; k++) tick(1);
    chk(write_in_progress, 1'b0);
    tick(4);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #800000;
    n_errors++;
    wrap_up();
  end
  initial begin
    {nrst, wel_set, qe, dual, prot, locks, rdy_cnt} = '0;
    dat = '{8'h11, 8'h22, 8'h33, 8'h44};
    tick(4);
    nrst = 1'b1;
    tick(4);
    // program without latch, then wrapping short program with busy read
    frame(`SFPB_OP_PP, 24'h001200, 1, 1'b0, 0);
    chk(write_in_progress, 1'b0);
    set_wel();
    frame(`SFPB_OP_PP, 24'h0012fe, 3, 1'b0, 0);
    chk(write_in_progress, 1'b1);
    frame(`SFPB_OP_BREAD, 24'h000000, 1, 1'b0, 0);
    chk(n_oe, 0);
    idle();
    chk(write_enable_latch, 1'b0);
    chk(n_wr, 3);
    chk(wr_mem[32'h12fe], 8'h11);
    chk(wr_mem[32'h12ff], 8'h22);
    chk(wr_mem[32'h1200], 8'h33);
    $display("program tests done");
    // mid-byte deselect, protected page, quad without and with enable
    set_wel();
    frame(`SFPB_OP_PP, 24'h001300, 1, 1'b0, 3);
    chk(write_in_progress, 1'b0);
    prot = 1'b1;
    frame(`SFPB_OP_PP, 24'h001400, 1, 1'b0, 0);
    chk(write_in_progress, 1'b0);
    chk(page, 16'h0014);
    chk(write_enable_latch, 1'b1);
    prot = 1'b0;
    frame(`SFPB_OP_QPP, 24'h003400, 1, 1'b1, 0);
    chk(write_in_progress, 1'b0);
    qe = 1'b1;
    frame(`SFPB_OP_QPP, 24'h003400, 2, 1'b1, 0);
    idle();
    chk(write_enable_latch, 1'b0);
    chk(wr_mem[32'h3400], 8'h11);
    chk(wr_mem[32'h3401], 8'h22);
    $display("refusal tests done");
    // clear, wrapping write and read of the buffer
    frame(`SFPB_OP_BCLR, 24'h000000, 0, 1'b0, 0);
    chk(write_in_progress, 1'b1);
    idle();
    frame(`SFPB_OP_BWRITE, 24'h0000ff, 2, 1'b0, 0);
    frame(`SFPB_OP_BREAD, 24'h0000ff, 3, 1'b0, 0);
    chk(got[0], 8'h11);
    chk(got[1], 8'h22);
    chk(got[2], 8'hff);
    // buffer to array program under a stalling array
    set_wel();
    n_wr = 0;
    frame(`SFPB_OP_BPROG, 24'h005600, 0, 1'b0, 0);
    idle();
    chk(n_wr, 256);
    chk(wr_mem[32'h56ff], 8'h11);
    chk(wr_mem[32'h5600], 8'h22);
    chk(wr_mem[32'h5601], 8'hff);
    chk(write_enable_latch, 1'b0);
    // page load into the buffer, read back one byte
    frame(`SFPB_OP_BLOAD, 24'h007800, 0, 1'b0, 0);
    chk(write_in_progress, 1'b1);
    idle();
    frame(`SFPB_OP_BREAD, 24'h000010, 1, 1'b0, 0);
    chk(got[0], 8'hef);
    // dual page mode: write and read wrap at the 512 byte end
    dual = 1'b1;
    frame(`SFPB_OP_BWRITE, 24'h0001ff, 2, 1'b0, 0);
    frame(`SFPB_OP_BREAD, 24'h0001ff, 2, 1'b0, 0);
    chk(got[0], 8'h11);
    chk(got[1], 8'h22);
    dual = 1'b0;
    $display("buffer tests done");
    // lockable register erase: accepted, locked, bad address, mid-byte
    set_wel();
    frame(`SFPB_OP_OTPERA, 24'h002000, 0, 1'b0, 0);
    chk(write_in_progress, 1'b1);
    idle();
    chk(n_erase, 1);
    chk(last_sel, 2'h1);
    set_wel();
    locks = 3'b010;
    frame(`SFPB_OP_OTPERA, 24'h002000, 0, 1'b0, 0);
    chk(write_in_progress, 1'b0);
    frame(`SFPB_OP_OTPERA, 24'h003200, 0, 1'b0, 0);
    chk(write_in_progress, 1'b0);
    frame(`SFPB_OP_OTPERA, 24'h003000, 0, 1'b0, 4);
    chk(write_in_progress, 1'b0);
    chk(n_erase, 1);
    chk(write_enable_latch, 1'b1);
    $display("erase tests done");
    wrap_up();
  end
endmodule

bind sfpb_core sfpb_properties chk_i (
  .CLOCK(CLOCK), .NRST(NRST), .CS_N(CS_N), .SIO_OE_N(SIO_OE_N),
  .OTP_LOCK_BITS(OTP_LOCK_BITS), .TARGET_PAGE(TARGET_PAGE),
  .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
  .ARRAY_WR_VALID(ARRAY_WR_VALID), .ARRAY_WR_ADDR(ARRAY_WR_ADDR),
  .ARRAY_RD_EN(ARRAY_RD_EN), .OTP_ERASE_START(OTP_ERASE_START),
  .OTP_ERASE_SEL(OTP_ERASE_SEL));
